// [logic/fpp_pkg.sv]
// Package: constants for the flash protect / program / power control block
package fpp_pkg;
    // ****************
    // Geometry
    // ****************
    localparam int ADDR_W = 24;
    localparam int PAGE_BYTES = 256;
    localparam int NUM_BLOCK_LOCKS = 126;
    localparam int NUM_SECTOR_LOCKS = 32;
    localparam int NUM_LOCKS = NUM_BLOCK_LOCKS + NUM_SECTOR_LOCKS;
    localparam int LOCK_IDX_W = 8;
    localparam logic [7:0] TOP_BLOCK = 8'hff;
    localparam logic [7:0] BOTTOM_BLOCK = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // ****************
    // Operation kinds
    // ****************
    typedef enum logic [2:0] {
        FPP_OP_WRITE_LATCH_ENABLE_CMD = 3'b000,
        FPP_OP_PROG = 3'b001,
        FPP_OP_SECT = 3'b010,
        FPP_OP_BLK = 3'b011,
        FPP_OP_CHIP = 3'b100,
        FPP_OP_STATUS_WRITE_CMD = 3'b101,
        FPP_OP_DSLEEP = 3'b110,
        FPP_OP_WAKE = 3'b111
    } fpp_op_e;
    typedef enum logic [1:0] {
        FPP_ST_STANDBY = 2'b00,
        FPP_ST_ACTIVE = 2'b01,
        FPP_ST_DEEP = 2'b10
    } fpp_pwr_e;
    // ****************
    // Timing (cycles at 10 MHz)
    // ****************
    localparam int CLK_NS = 100;
    localparam int PROG_US = 400;
    localparam int ERASE_US = 1000;
    localparam int STATUS_WRITE_CMD_US = 100;
    localparam int PROG_CYC = PROG_US * 1000 / CLK_NS;
    localparam int ERASE_CYC = ERASE_US * 1000 / CLK_NS;
    localparam int STATUS_WRITE_CMD_CYC = STATUS_WRITE_CMD_US * 1000 / CLK_NS;
    localparam int CNT_W = 24;
    localparam logic [7:0] LOCKS_RESET = 8'hff;
endpackage

// [logic/fpp_lock_mem.sv]
// Lock-bit storage: one bit per locked block or sector, read data registered
`timescale 1ns/1ps
module fpp_lock_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [fpp_pkg::LOCK_IDX_W-1:0] waddr,
    input wire logic wdata,
    input wire logic set_all,
    input wire logic clr_all,
    // Read port
    input wire logic [fpp_pkg::LOCK_IDX_W-1:0] raddr,
    output logic rdata
);
    logic [fpp_pkg::NUM_LOCKS-1:0] bits_q;
    genvar i;
    generate
        for (i = 0; i < fpp_pkg::NUM_LOCKS; i++) begin : g_bit
            wire hit = we && (waddr == fpp_pkg::LOCK_IDX_W'(i));
            always_ff @(posedge clk) begin
                // Every lock powers up set, whole array protected
                if (!rst_n || set_all) begin
                    bits_q[i] <= 1'b1;
                end else if (clr_all) begin
                    bits_q[i] <= 1'b0;
                end else if (hit) begin
                    bits_q[i] <= wdata;
                end
            end
        end
    endgenerate
    wire in_range = raddr < fpp_pkg::LOCK_IDX_W'(fpp_pkg::NUM_LOCKS);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 1'b1;
        end else begin
            rdata <= in_range ? bits_q[raddr] : 1'b1;
        end
    end
endmodule

// [logic/fpp_ctrl.sv]
// Write protection decode, program/erase acceptance and power state control
`timescale 1ns/1ps
module fpp_ctrl #(
    parameter int PROG_CYCLES = fpp_pkg::PROG_CYC,
    parameter int ERASE_CYCLES = fpp_pkg::ERASE_CYC,
    parameter int STATUS_WRITE_CMD_CYCLES = fpp_pkg::STATUS_WRITE_CMD_CYC,
    parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link pins, asynchronous to clk
    input wire logic chip_sel_n,
    input wire logic sclk,
    // Decoded command from the instruction decoder
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic [8:0] cmd_len,
    input wire logic [7:0] cmd_status,
    input wire logic cmd_blk32,
    // Lock bit maintenance
    input wire logic lock_we,
    input wire logic lock_value,
    input wire logic lock_set_all,
    input wire logic lock_clr_all,
    // Status bits
    input wire logic protect_scheme_select,
    output logic [7:0] status_q,
    output logic busy,
    output logic write_latch,
    // Operation results
    output logic accept,
    output logic reject,
    output logic [23:0] op_addr_q,
    output logic [23:0] op_end_q,
    output logic [7:0] fill_byte_q,
    output logic prog_and_mode_q,
    output logic [7:0] device_id_q,
    output logic id_valid,
    output logic [1:0] power_state,
    output logic sclk_rise
);
    // ****************
    // Pin synchronisers
    // ****************
    logic cs_m_q, cs_s_q, ck_m_q, ck_s_q, ck_p_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            ck_m_q <= 1'b0;
            ck_s_q <= 1'b0;
            ck_p_q <= 1'b0;
        end else begin
            cs_m_q <= chip_sel_n;
            cs_s_q <= cs_m_q;
            ck_m_q <= sclk;
            ck_s_q <= ck_m_q;
            ck_p_q <= ck_s_q;
        end
    end
    assign sclk_rise = ck_s_q && !ck_p_q && !cs_s_q;
    // ****************
    // Status fields
    // ****************
    // status_q: [7]cmp [6]sec [5]tb [4:2]bp [1]wel [0]busy
    wire complement_protect = status_q[7];
    wire sector_granularity = status_q[6];
    wire top_bottom_select = status_q[5];
    wire block_protect_field_hi = status_q[4];
    wire block_protect_field_mid = status_q[3];
    wire block_protect_field_lo = status_q[2];
    wire [2:0] bp = {block_protect_field_hi, block_protect_field_mid, block_protect_field_lo};
    // ****************
    // Range decode
    // ****************
    // Region size for the plain map; the complement inverts the protected side
    wire [4:0] sec_sh = bp[2] ? 5'd15 : 5'(5'd11 + {3'b000, bp[1:0]});
    wire [4:0] blk_sh = 5'(5'd17 + {2'b00, bp});
    wire [4:0] sh = sector_granularity ? sec_sh : blk_sh;
    wire [24:0] rsize = 25'(25'h1 << sh);
    wire [24:0] lo_edge = rsize;
    wire [24:0] hi_edge = 25'(25'h1000000 - rsize);
    logic [23:0] op_end_d;
    wire [23:0] start_d = (cmd_op == fpp_pkg::FPP_OP_SECT) ? {cmd_addr[23:12], 12'h000} :
        (cmd_op == fpp_pkg::FPP_OP_BLK) ? (cmd_blk32 ? {cmd_addr[23:15], 15'h0} :
        {cmd_addr[23:16], 16'h0}) : (cmd_op == fpp_pkg::FPP_OP_CHIP) ? 24'h0 : cmd_addr;
    // Whole erase unit is judged, not only the byte that the host named
    wire [24:0] s_addr = {1'b0, start_d};
    wire [24:0] e_addr = {1'b0, op_end_d};
    // Plain map: bottom region [0,rsize) if tb, else top [hi_edge,end)
    wire touch_plain = top_bottom_select ? (s_addr < lo_edge) : (e_addr >= hi_edge);
    // Complement: only the plain region stays writable
    wire inside_plain = top_bottom_select ? (e_addr < lo_edge) : (s_addr >= hi_edge);
    wire bp_none = (bp == 3'b000);
    wire bp_all = (bp == 3'b111);
    wire range_prot = complement_protect ?
        (bp_all ? 1'b0 : (bp_none ? 1'b1 : !inside_plain)) :
        (bp_none ? 1'b0 : (bp_all ? 1'b1 : touch_plain));
    // ****************
    // Lock decode
    // ****************
    // Edge blocks map to 16 sector locks each; middle blocks to one lock
    function automatic logic [7:0] lock_index(input logic [23:0] a);
        logic [7:0] b;
        b = a[23:16];
        if (b == fpp_pkg::BOTTOM_BLOCK) begin
            lock_index = {4'h0, a[15:12]};
        end else if (b == fpp_pkg::TOP_BLOCK) begin
            lock_index = {4'h1, a[15:12]};
        end else begin
            lock_index = 8'(8'd31 + b);
        end
    endfunction
    logic lock_rd;
    wire [7:0] lk_idx = lock_index(cmd_addr);
    fpp_lock_mem u_locks (
        .clk(clk),
        .rst_n(rst_n),
        .we(lock_we),
        .waddr(lk_idx),
        .wdata(lock_value),
        .set_all(lock_set_all),
        .clr_all(lock_clr_all),
        .raddr(lk_idx),
        .rdata(lock_rd)
    );
    // Lock check holds the command one cycle for the registered read
    logic pend_q;
    logic [2:0] pop_q;
    logic [23:0] paddr_q, pend_end_q;
    logic [7:0] pstat_q;
    logic prange_q;
    // Unit erases touch several locks; treat chip/unit as covered by one lookup
    // except chip erase, which any set lock in scheme 1 refuses.
    logic any_lock_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            any_lock_q <= 1'b1;
        end else if (lock_set_all || (lock_we && lock_value)) begin
            any_lock_q <= 1'b1;
        end else if (lock_clr_all) begin
            any_lock_q <= 1'b0;
        end
    end
    wire lock_prot = (pop_q == fpp_pkg::FPP_OP_CHIP) ? any_lock_q : lock_rd;
    wire prot = protect_scheme_select ? lock_prot : prange_q;
    // ****************
    // Command acceptance
    // ****************
    wire [8:0] len1 = (cmd_len == 9'd0) ? 9'd1 : cmd_len;
    wire [8:0] room = 9'(9'h100 - {1'b0, cmd_addr[7:0]});
    wire [8:0] plen = (len1 > room) ? room : len1;
    always_comb begin
        case (fpp_pkg::fpp_op_e'(cmd_op))
            fpp_pkg::FPP_OP_PROG: op_end_d = 24'(cmd_addr + {15'h0, plen} - 24'h1);
            fpp_pkg::FPP_OP_SECT: op_end_d = {cmd_addr[23:12], 12'hfff};
            fpp_pkg::FPP_OP_BLK: op_end_d = cmd_blk32 ? {cmd_addr[23:15], 15'h7fff} :
                {cmd_addr[23:16], 16'hffff};
            fpp_pkg::FPP_OP_CHIP: op_end_d = 24'hffffff;
            default: op_end_d = cmd_addr;
        endcase
    end
    wire deep = (power_state == fpp_pkg::FPP_ST_DEEP);
    wire is_write = (cmd_op >= fpp_pkg::FPP_OP_PROG) && (cmd_op <= fpp_pkg::FPP_OP_STATUS_WRITE_CMD);
    wire live = cmd_valid && !cs_s_q && !busy && !pend_q;
    wire go_wake = cmd_valid && deep && (cmd_op == fpp_pkg::FPP_OP_WAKE);
    wire go_cmd = live && !deep;
    wire need_chk = go_cmd && is_write && (cmd_op != fpp_pkg::FPP_OP_STATUS_WRITE_CMD);
    wire nowel = go_cmd && is_write && !write_latch;
    wire start_ok = pend_q && !prot;
    wire status_write_cmd_ok = go_cmd && (cmd_op == fpp_pkg::FPP_OP_STATUS_WRITE_CMD) && write_latch;
    assign accept = start_ok || status_write_cmd_ok;
    assign reject = nowel || (cmd_valid && deep && !go_wake) || (pend_q && prot);
    // ****************
    // Internal cycle counter
    // ****************
    logic [fpp_pkg::CNT_W-1:0] cnt_q;
    assign busy = status_q[0];
    assign write_latch = status_q[1];
    wire [fpp_pkg::CNT_W-1:0] dur = (pop_q == fpp_pkg::FPP_OP_PROG) ?
        fpp_pkg::CNT_W'(PROG_CYCLES) : fpp_pkg::CNT_W'(ERASE_CYCLES);
    wire done = busy && (cnt_q == '0);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= 8'h00;
            cnt_q <= '0;
            pend_q <= 1'b0;
            pop_q <= 3'b000;
            paddr_q <= '0;
            pend_end_q <= '0;
            prange_q <= 1'b0;
            pstat_q <= 8'h00;
        end else begin
            pend_q <= need_chk && write_latch;
            if (need_chk) begin
                pop_q <= cmd_op;
                paddr_q <= start_d;
                pend_end_q <= op_end_d;
                prange_q <= range_prot;
            end
            if (go_cmd && cmd_op == fpp_pkg::FPP_OP_WRITE_LATCH_ENABLE_CMD) begin
                status_q[1] <= 1'b1;
            end
            if (status_write_cmd_ok) begin
                pstat_q <= cmd_status;
                status_q[0] <= 1'b1;
                status_q[1] <= 1'b0;
                cnt_q <= fpp_pkg::CNT_W'(STATUS_WRITE_CMD_CYCLES);
                pop_q <= fpp_pkg::FPP_OP_STATUS_WRITE_CMD;
            end else if (start_ok) begin
                status_q[0] <= 1'b1;
                status_q[1] <= 1'b0;
                cnt_q <= dur;
            end else if (pend_q) begin
                status_q[1] <= 1'b0;
            end else if (done) begin
                status_q[0] <= 1'b0;
                if (pop_q == fpp_pkg::FPP_OP_STATUS_WRITE_CMD) begin
                    status_q[7:2] <= pstat_q[7:2];
                end
            end else if (busy) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
    // ****************
    // Result registers
    // ****************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_addr_q <= '0;
            op_end_q <= '0;
            fill_byte_q <= 8'h00;
            prog_and_mode_q <= 1'b0;
        end else if (start_ok) begin
            op_addr_q <= paddr_q;
            op_end_q <= pend_end_q;
            prog_and_mode_q <= (pop_q == fpp_pkg::FPP_OP_PROG);
            fill_byte_q <= fpp_pkg::ERASED_BYTE;
        end
    end
    // ****************
    // Power state
    // ****************
    logic [1:0] pwr_q;
    assign power_state = pwr_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_q <= fpp_pkg::FPP_ST_STANDBY;
            device_id_q <= 8'h00;
            id_valid <= 1'b0;
        end else begin
            id_valid <= go_wake;
            case (pwr_q)
                fpp_pkg::FPP_ST_DEEP: begin
                    if (go_wake) begin
                        pwr_q <= fpp_pkg::FPP_ST_ACTIVE;
                        device_id_q <= DEVICE_ID;
                    end
                end
                fpp_pkg::FPP_ST_ACTIVE, fpp_pkg::FPP_ST_STANDBY: begin
                    if (go_cmd && cmd_op == fpp_pkg::FPP_OP_DSLEEP) begin
                        pwr_q <= fpp_pkg::FPP_ST_DEEP;
                    end else if (!cs_s_q || busy || pend_q) begin
                        pwr_q <= fpp_pkg::FPP_ST_ACTIVE;
                    end else begin
                        pwr_q <= fpp_pkg::FPP_ST_STANDBY;
                    end
                end
                default: pwr_q <= fpp_pkg::FPP_ST_STANDBY;
            endcase
        end
    end
endmodule

// [tb/fpp_ctrl_properties.sv]
// Checker: timing properties at the protect/program/power control ports
`timescale 1ns/1ps
module fpp_ctrl_properties #(
    parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests
    input wire logic chip_sel_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    // Results
    input wire logic busy,
    input wire logic write_latch,
    input wire logic accept,
    input wire logic reject,
    input wire logic [7:0] device_id_q,
    input wire logic id_valid,
    input wire logic [1:0] power_state
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_busy_start; accept |=> busy; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy missing after accept");
    property p_busy_hold; $rose(busy) |-> busy[*4]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_busy_end; $rose(busy) |-> ##[1:60] !busy; endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy never cleared");
    property p_latch_req; accept |-> write_latch; endproperty
    a_latch_req: assert property (p_latch_req) else $error("accept without latch");
    property p_latch_clr; accept |=> !write_latch; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after accept");
    property p_not_standby; busy |-> power_state != fpp_pkg::FPP_ST_STANDBY; endproperty
    a_not_standby: assert property (p_not_standby) else $error("standby while busy");
    // Four cycles cover the two-stage select synchroniser plus the state register
    property p_sel_active; (!chip_sel_n)[*4] |-> power_state != fpp_pkg::FPP_ST_STANDBY; endproperty
    a_sel_active: assert property (p_sel_active) else $error("selected but standby");
    property p_idle_standby; (chip_sel_n && !busy)[*4] |-> power_state != fpp_pkg::FPP_ST_ACTIVE;
    endproperty
    a_idle_standby: assert property (p_idle_standby) else $error("idle but active");
    property p_deep_quiet; power_state == fpp_pkg::FPP_ST_DEEP |-> !accept; endproperty
    a_deep_quiet: assert property (p_deep_quiet) else $error("accept in deep sleep");
    property p_deep_reject; (!chip_sel_n)[*4] ##0 (cmd_valid && cmd_op != 3'h7 &&
        power_state == fpp_pkg::FPP_ST_DEEP) |-> reject; endproperty
    a_deep_reject: assert property (p_deep_reject) else $error("deep command not refused");
    property p_id; id_valid |-> device_id_q == DEVICE_ID; endproperty
    a_id: assert property (p_id) else $error("wrong identifier");
endmodule
bind fpp_ctrl fpp_ctrl_properties #(.DEVICE_ID(DEVICE_ID)) fpp_ctrl_properties_inst (
    .clk(clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .busy(busy), .write_latch(write_latch), .accept(accept),
    .reject(reject), .device_id_q(device_id_q), .id_valid(id_valid),
    .power_state(power_state)
);

// [tb/fpp_host_model.sv]
// Host link model: chip select and a link clock that runs only inside frames
`timescale 1ns/1ps
module fpp_host_model (
    // Frame request
    input wire logic sel,
    // Link pins
    output logic chip_sel_n,
    output logic sclk,
    output int edges
);
    initial begin
        chip_sel_n = 1'b1;
        sclk = 1'b0;
        edges = 0;
        forever begin
            wait (sel);
            #37 chip_sel_n = 1'b0;
            while (sel) begin
                #400 sclk = 1'b1;
                edges++;
                #400 sclk = 1'b0;
            end
            // Clock parks low so no stray edge is seen while deselected
            #100 chip_sel_n = 1'b1;
        end
    end
endmodule

// [tb/fpp_ctrl_tb.sv]
// Testbench: protection decode, program/erase acceptance and power states
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module fpp_ctrl_tb;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    logic clk, rst_n, sel, cmd_valid, cmd_blk32, lock_we, lock_value, lock_set_all, lock_clr_all;
    logic pss, chip_sel_n, sclk, busy, write_latch, accept, reject, prog_and_mode_q;
    logic id_valid, sclk_rise;
    logic [2:0] cmd_op;
    logic [23:0] cmd_addr, op_addr_q, op_end_q;
    logic [8:0] cmd_len;
    logic [7:0] cmd_status, status_q, fill_byte_q, device_id_q, id_seen;
    logic [1:0] power_state;
    logic [43:0] ent;
    int bad_count, samples_checked, n_acc, n_rej, n_rise, edges, i;
    // Entry: status, latch first, op, address, expected accept
    logic [43:0] tbl [12] = '{44'h84_1_1_fbff00_0, 44'h84_1_1_fc0000_1, 44'ha4_1_1_03ff00_1,
        44'ha4_1_2_040000_0, 44'ha4_1_4_000000_0, 44'hc4_1_1_fff000_1, 44'hc4_1_2_ffe000_0,
        44'hf0_1_1_007f00_1, 44'hf0_1_3_000000_0, 44'h80_1_1_000000_0, 44'h9c_0_1_000100_0,
        44'h9c_1_4_000000_1};
    fpp_ctrl #(.PROG_CYCLES(40), .ERASE_CYCLES(8), .STATUS_WRITE_CMD_CYCLES(4), .DEVICE_ID(ID)) fpp_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .sclk(sclk), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_status(cmd_status),
        .cmd_blk32(cmd_blk32), .lock_we(lock_we), .lock_value(lock_value),
        .lock_set_all(lock_set_all), .lock_clr_all(lock_clr_all), .protect_scheme_select(pss),
        .status_q(status_q), .busy(busy), .write_latch(write_latch), .accept(accept),
        .reject(reject), .op_addr_q(op_addr_q), .op_end_q(op_end_q), .fill_byte_q(fill_byte_q),
        .prog_and_mode_q(prog_and_mode_q), .device_id_q(device_id_q), .id_valid(id_valid),
        .power_state(power_state), .sclk_rise(sclk_rise));
    fpp_host_model fpp_host_model_inst (.sel(sel), .chip_sel_n(chip_sel_n), .sclk(sclk),
        .edges(edges));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (accept) n_acc++;
        if (reject) n_rej++;
        if (sclk_rise) n_rise++;
        if (id_valid) id_seen = device_id_q;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic issue(input logic [2:0] o, input logic [23:0] a);
        wait_idle();
        cmd_op = o;
        cmd_addr = a;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic op(input logic [2:0] o, input logic [23:0] a, input logic w, input logic e);
        int na, nr;
        if (w) issue(3'h0, a);
        na = n_acc;
        nr = n_rej;
        issue(o, a);
        `CHK(n_acc - na == 1, e)
        `CHK(n_rej - nr == 1, !e)
    endtask
    task automatic pulse(ref logic s, input logic [23:0] a);
        cmd_addr = a;
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        {rst_n, sel, cmd_valid, cmd_blk32, lock_we, lock_value, lock_set_all, lock_clr_all} = '0;
        {pss, cmd_op, cmd_addr, cmd_status, id_seen} = '0;
        cmd_len = 9'h010;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        `CHK(power_state, fpp_pkg::FPP_ST_STANDBY)
        `CHK(status_q, 8'h00)
        sel = 1'b1;
        repeat (6) @(negedge clk);
        for (i = 0; i < 12; i++) begin
            ent = tbl[i];
            cmd_status = ent[43:36];
            op(3'h5, 24'h000000, 1'b1, 1'b1);
            op(ent[30:28], ent[27:4], ent[32], ent[0]);
        end
        `CHK({op_addr_q, op_end_q, fill_byte_q, prog_and_mode_q}, {24'h0, 24'hffffff, 8'hff, 1'b0})
        cmd_len = 9'h020;
        op(3'h1, 24'h1234f0, 1'b1, 1'b1);
        `CHK({op_end_q, prog_and_mode_q}, {24'h1234ff, 1'b1})
        cmd_blk32 = 1'b1;
        op(3'h3, 24'h018000, 1'b1, 1'b1);
        `CHK(op_end_q, 24'h01ffff)
        cmd_blk32 = 1'b0;
        $display("range protection done");
        cmd_status = 8'h80;
        op(3'h5, 24'h000000, 1'b1, 1'b1);
        pss = 1'b1;
        op(3'h1, 24'h100000, 1'b1, 1'b0);
        pulse(lock_we, 24'h100000);
        op(3'h1, 24'h100000, 1'b1, 1'b1);
        op(3'h1, 24'h110000, 1'b1, 1'b0);
        pulse(lock_we, 24'hfff000);
        op(3'h1, 24'hfff000, 1'b1, 1'b1);
        op(3'h1, 24'hffe000, 1'b1, 1'b0);
        pulse(lock_clr_all, 24'h000000);
        op(3'h1, 24'h200000, 1'b1, 1'b1);
        pulse(lock_set_all, 24'h000000);
        op(3'h1, 24'h200000, 1'b1, 1'b0);
        pss = 1'b0;
        op(3'h1, 24'h100000, 1'b1, 1'b0);
        $display("lock protection done");
        cmd_status = 8'h9c;
        op(3'h5, 24'h000000, 1'b1, 1'b1);
        `CHK(power_state, fpp_pkg::FPP_ST_ACTIVE)
        op(3'h1, 24'h300000, 1'b1, 1'b1);
        sel = 1'b0;
        repeat (15) @(negedge clk);
        `CHK({busy, power_state}, {1'b1, fpp_pkg::FPP_ST_ACTIVE})
        wait_idle();
        repeat (4) @(negedge clk);
        `CHK(power_state, fpp_pkg::FPP_ST_STANDBY)
        `CHK(n_rise, edges)
        sel = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(power_state, fpp_pkg::FPP_ST_ACTIVE)
        issue(3'h6, 24'h000000);
        `CHK(power_state, fpp_pkg::FPP_ST_DEEP)
        op(3'h1, 24'h300000, 1'b1, 1'b0);
        issue(3'h7, 24'h000000);
        `CHK({id_seen, power_state}, {ID, fpp_pkg::FPP_ST_ACTIVE})
        $display("power states done");
        wrap_up();
    end
endmodule
